// [hw/sas_pkg.sv]
// Constants and types shared by the serial converter sequencer
package sas_pkg;
    // ============================================================
    // Serial frame
    localparam int CTRL_BITS = 8;
    localparam int RES_BITS = 12;
    localparam logic [3:0] RX_LAST = 4'h8;
    localparam logic [4:0] K_STROBE = 5'h01;
    localparam logic [4:0] K_FIRST = 5'h02;
    localparam logic [4:0] K_LAST = 5'h0D;
    localparam logic [4:0] K_OVERLAP = 5'h07;
    // ============================================================
    // Control byte fields
    localparam int CB_CH_HI = 6;
    localparam int CB_CH_LO = 4;
    localparam int CB_POL = 3;
    localparam int CB_SGL = 2;
    localparam int CB_PM_HI = 1;
    localparam int CB_PM_LO = 0;
    // ============================================================
    // Register map
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_TEST_CODE = 12'h004;
    localparam logic [11:0] OFS_STATUS = 12'h008;
    localparam logic [11:0] OFS_RESULT = 12'h00C;
    localparam int ST_CONV = 0;
    localparam int ST_PM_LO = 1;
    localparam int ST_HW_SHUTDOWN_N = 3;
    localparam int ST_CB_LO = 8;
    localparam logic RST_TEST_MODE = 1'b0;
    localparam logic [11:0] RST_TEST_CODE = 12'h000;
    // ============================================================
    // Power states
    typedef enum logic [1:0] {
        PM_DEEP_SLEEP = 2'b00,
        PM_QUICK_WAKE = 2'b01,
        PM_LOW_IDLE = 2'b10,
        PM_NORMAL = 2'b11
    } sas_pmode_e;
endpackage : sas_pkg

// [hw/sas_sync.sv]
// Two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/1ns
module sas_sync #(
    parameter int W = 1,
    // Idle level of each pin, so that leaving reset shows no false edge
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Data
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= RST_VAL;
            sync_o <= RST_VAL;
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end
endmodule : sas_sync

// [hw/sas_top.sv]
// Serial command, conversion sequencing and power-mode logic
// Summary of operation
// R1: Unipolar straight binary, bipolar two's complement
// R2: Result bits change on rising edge, MSB first
// R3: Strobe high one period after control byte
// R4: Twelve decisions on rising edges after strobe
// R5: Select high floats outputs; next fall drives strobe low; the code leaves the output enables unchanged while HW_SHUTDOWN_N is low
// R6: Host finishes conversion within 120 us
// R7: First one after select fall is start
// R8: Conversion starts on falling edge after bit eight
// R9: Start accepted when idle or after bit four; the code accepts it once result bit 6 has gone out (k >= K_OVERLAP)
// R10: Only shutdown aborts an accepted conversion
// R11: Back-to-back conversions every 16 clocks
// R12: Host sends 16 zeros when select tied low
// R13: Reset lands in normal mode, strobe low
// R14: Host waits 10 us after power-up
// R15: Zeros shifted out before first conversion
// R16: Soft modes after conversion; shutdown immediate
// R17: Start bit wakes; programmed mode after conversion
// R18: Host waits 2 us after wake-ups
// R19: Two mode bits pick four power states
// R20: Each byte's mode field applies after conversion
// R21: Host limits clock in light low-power modes
// R22: Host issues dummy conversion after deep sleep
// R23: Control byte fields decoded MSB first
// R24: Command bit sampled on rising clock edge
// R25: Result framed with leading and trailing zeros
// R26: Zeros driven after last result bit
`timescale 1ns/1ns
module sas_top
    import sas_pkg::*;
(
    // System
    input wire logic CLOCK,
    input wire logic RST,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Serial link pins
    input wire logic SCLK,
    input wire logic CS_N,
    input wire logic DIN,
    input wire logic HW_SHUTDOWN_N,
    output logic DOUT,
    output logic DOUT_OE,
    output logic STROBE_OUT,
    output logic STROBE_OUT_OE,
    // Analog core side
    input wire logic COMP_DECISION,
    output logic [1:0] POWER_MODE,
    output logic CONV_ACTIVE,
    output logic HW_SHUTDOWN,
    output logic [2:0] CHANNEL,
    output logic SINGLE_ENDED
);
    // ============================================================
    // State
    typedef struct packed {
        logic sclk_d;
        logic cs_n_d;
        logic [3:0] rx_cnt;
        logic [CTRL_BITS-1:0] rx_sh;
        logic launch_pend;
        logic [CTRL_BITS-1:0] ctl;
        logic conv;
        logic [4:0] k;
        logic [RES_BITS-1:0] res;
        logic [RES_BITS-1:0] last_res;
        sas_pmode_e pmode;
        logic hw_shutdown_n;
        logic dout;
        logic dout_oe;
        logic strb;
        logic strb_oe;
        logic test_mode;
        logic [RES_BITS-1:0] test_code;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } sas_state_s;

    sas_state_s st_r;
    sas_state_s st_nxt;
    logic sclk_s;
    logic cs_n_s;
    logic din_s;
    logic hw_shutdown_n_n_s;
    logic comp_s;
    logic rise;
    logic fall;
    logic start_ok;
    logic dec_bit;
    logic [4:0] k_inc;
    logic [3:0] idx;

    // Every pin from the link passes two flops first
    // Reset to idle levels: clock low, select high, shutdown released
    sas_sync #(
        .W(5),
        .RST_VAL(5'h0A)
    ) u_sync (
        .clk(CLOCK),
        .rst(RST),
        .async_i({SCLK, CS_N, DIN, HW_SHUTDOWN_N, COMP_DECISION}),
        .sync_o({sclk_s, cs_n_s, din_s, hw_shutdown_n_n_s, comp_s})
    );

    function automatic logic apb_hit(input logic [11:0] a, input logic [11:0] ofs);
        return a == ofs;
    endfunction : apb_hit

    // ============================================================
    // Edge finding and helpers
    assign rise = sclk_s & ~st_r.sclk_d;
    assign fall = ~sclk_s & st_r.sclk_d;
    assign k_inc = st_r.k + 5'h01;
    assign idx = 4'(K_LAST - k_inc);
    // Overlapped entry opens once result bit 6 has gone out
    assign start_ok = ~st_r.launch_pend & (~st_r.conv | (st_r.k >= K_OVERLAP)); // R9
    // Bipolar flips the MSB decision: offset binary to two's complement
    assign dec_bit = (st_r.test_mode ? st_r.test_code[idx] : comp_s)
                     ^ ((idx == 4'(RES_BITS - 1)) & ~st_r.ctl[CB_POL]); // R1

    always_comb begin
        st_nxt = st_r;
        st_nxt.sclk_d = sclk_s;
        st_nxt.cs_n_d = cs_n_s;
        // ========================================================
        // Serial side
        if (!hw_shutdown_n_n_s) begin
            // Shutdown kills conversion, pending launch, receive count, strobe and output bit at once, even a running conversion
            st_nxt.hw_shutdown_n = 1'b1; // R16
            st_nxt.conv = 1'b0; // R10
            st_nxt.launch_pend = 1'b0;
            st_nxt.rx_cnt = 4'h0;
            st_nxt.strb = 1'b0;
            st_nxt.dout = 1'b0;
        end else begin
            if (st_r.hw_shutdown_n) begin
                st_nxt.hw_shutdown_n = 1'b0;
                st_nxt.pmode = PM_NORMAL;
            end
            if (cs_n_s) begin
                st_nxt.dout_oe = 1'b0; // R5
                st_nxt.strb_oe = 1'b0; // R5
            end else if (st_r.cs_n_d) begin
                st_nxt.dout_oe = 1'b1;
                st_nxt.strb_oe = 1'b1;
                st_nxt.strb = 1'b0; // R5
            end
            if (rise) begin
                // Idle output is zero, before and after any result
                st_nxt.dout = 1'b0; // R15 R26
                st_nxt.strb = 1'b0;
                if (st_r.conv) begin
                    st_nxt.k = k_inc;
                    if (k_inc == K_STROBE) begin
                        st_nxt.strb = 1'b1; // R3
                    end else if (k_inc >= K_FIRST && k_inc <= K_LAST) begin
                        st_nxt.dout = dec_bit; // R2 R4 R25
                        st_nxt.res = {st_r.res[RES_BITS-2:0], dec_bit}; // R4
                        if (k_inc == K_LAST) begin
                            st_nxt.conv = 1'b0;
                            st_nxt.last_res = {st_r.res[RES_BITS-2:0], dec_bit};
                            // Programmed mode only once the conversion is over
                            st_nxt.pmode = sas_pmode_e'(st_r.ctl[CB_PM_HI:CB_PM_LO]); // R16 R20
                        end
                    end
                end
                if (!cs_n_s) begin
                    if (st_r.rx_cnt == 4'h0) begin
                        // Leading zeros are ignored; a one is the start bit
                        if (din_s && start_ok) begin // R7
                            st_nxt.rx_cnt = 4'h1;
                            st_nxt.rx_sh = {{(CTRL_BITS-1){1'b0}}, 1'b1};
                            st_nxt.pmode = PM_NORMAL; // R17
                        end
                    end else begin
                        st_nxt.rx_sh = {st_r.rx_sh[CTRL_BITS-2:0], din_s}; // R24 R23
                        if (st_r.rx_cnt == RX_LAST - 4'h1) begin
                            st_nxt.rx_cnt = 4'h0;
                            st_nxt.launch_pend = 1'b1;
                        end else begin
                            st_nxt.rx_cnt = st_r.rx_cnt + 4'h1;
                        end
                    end
                end
            end
            if (fall && st_r.launch_pend) begin
                st_nxt.launch_pend = 1'b0;
                st_nxt.conv = 1'b1; // R8 R11
                st_nxt.k = 5'h00;
                st_nxt.res = '0;
                st_nxt.ctl = st_r.rx_sh; // R23
                st_nxt.pmode = PM_NORMAL; // R19
            end
        end
        // ========================================================
        // APB slave, one wait state
        st_nxt.pready = 1'b0;
        st_nxt.pslverr = 1'b0;
        if (PSEL && PENABLE && !st_r.pready) begin
            st_nxt.pready = 1'b1;
            st_nxt.prdata = 32'h00000000;
            if (apb_hit(PADDR, OFS_CTRL)) begin
                st_nxt.prdata[0] = st_r.test_mode;
            end else if (apb_hit(PADDR, OFS_TEST_CODE)) begin
                st_nxt.prdata[RES_BITS-1:0] = st_r.test_code;
            end else if (apb_hit(PADDR, OFS_STATUS)) begin
                st_nxt.prdata[ST_CONV] = st_r.conv;
                st_nxt.prdata[ST_PM_LO+1:ST_PM_LO] = st_r.pmode;
                st_nxt.prdata[ST_HW_SHUTDOWN_N] = st_r.hw_shutdown_n;
                st_nxt.prdata[ST_CB_LO+CTRL_BITS-1:ST_CB_LO] = st_r.ctl;
            end else if (apb_hit(PADDR, OFS_RESULT)) begin
                st_nxt.prdata[RES_BITS-1:0] = st_r.last_res;
            end else begin
                st_nxt.pslverr = 1'b1;
            end
        end
        // Write lands on the edge where the master sees ready
        if (PSEL && PENABLE && st_r.pready && PWRITE) begin
            if (apb_hit(PADDR, OFS_CTRL)) begin
                st_nxt.test_mode = PWDATA[0];
            end else if (apb_hit(PADDR, OFS_TEST_CODE)) begin
                st_nxt.test_code = PWDATA[RES_BITS-1:0];
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            st_r <= '0;
            st_r.sclk_d <= 1'b0;
            st_r.cs_n_d <= 1'b1;
            st_r.pmode <= PM_NORMAL; // R13
            st_r.dout_oe <= 1'b1;
            st_r.strb_oe <= 1'b1;
            st_r.test_mode <= RST_TEST_MODE;
            st_r.test_code <= RST_TEST_CODE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ============================================================
    // Outputs
    assign PRDATA = st_r.prdata;
    assign PREADY = st_r.pready;
    assign PSLVERR = st_r.pslverr;
    assign DOUT = st_r.dout;
    assign DOUT_OE = st_r.dout_oe;
    assign STROBE_OUT = st_r.strb;
    assign STROBE_OUT_OE = st_r.strb_oe;
    assign POWER_MODE = st_r.pmode;
    assign CONV_ACTIVE = st_r.conv;
    assign HW_SHUTDOWN = st_r.hw_shutdown_n;
    assign CHANNEL = st_r.ctl[CB_CH_HI:CB_CH_LO];
    assign SINGLE_ENDED = st_r.ctl[CB_SGL];

    // ============================================================
    // Checks
    property p_strobe_slot;
        @(posedge CLOCK) disable iff (RST)
        $rose(st_r.strb) |-> st_r.conv && st_r.k == K_STROBE;
    endproperty
    a_strobe_slot: assert property (p_strobe_slot) else $error("Strobe outside its slot"); // R3

    property p_strobe_hold;
        @(posedge CLOCK) disable iff (RST)
        st_r.strb && !rise && hw_shutdown_n_n_s && !(cs_n_s == 1'b0 && st_r.cs_n_d) |=> st_r.strb;
    endproperty
    a_strobe_hold: assert property (p_strobe_hold) else $error("Strobe dropped early"); // R3

    property p_launch;
        @(posedge CLOCK) disable iff (RST)
        fall && st_r.launch_pend && hw_shutdown_n_n_s |=> st_r.conv && st_r.k == 5'h00 && !st_r.launch_pend;
    endproperty
    a_launch: assert property (p_launch) else $error("Conversion not launched on fall"); // R8

    property p_float;
        @(posedge CLOCK) disable iff (RST)
        !RST && cs_n_s && hw_shutdown_n_n_s |=> !DOUT_OE && !STROBE_OUT_OE;
    endproperty
    a_float: assert property (p_float) else $error("Outputs driven while deselected"); // R5

    property p_shutdown;
        @(posedge CLOCK) disable iff (RST)
        !hw_shutdown_n_n_s |=> !st_r.conv && HW_SHUTDOWN && !st_r.launch_pend;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("Shutdown did not abort"); // R16

    property p_idle_zero;
        @(posedge CLOCK) disable iff (RST)
        rise && hw_shutdown_n_n_s && (!st_r.conv || st_r.k >= K_LAST) |=> !DOUT;
    endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("Nonzero output outside result"); // R26

    property p_zero_ignored;
        @(posedge CLOCK) disable iff (RST)
        rise && !cs_n_s && !din_s && st_r.rx_cnt == 4'h0 |=> st_r.rx_cnt == 4'h0;
    endproperty
    a_zero_ignored: assert property (p_zero_ignored) else $error("Zero taken as start"); // R7

    property p_mode_after;
        @(posedge CLOCK) disable iff (RST)
        rise && hw_shutdown_n_n_s && st_r.conv && st_r.k == K_LAST - 5'h01
        && !(din_s && !cs_n_s && start_ok && st_r.rx_cnt == 4'h0)
        |=> !st_r.conv && POWER_MODE == $past(st_r.ctl[CB_PM_HI:CB_PM_LO]);
    endproperty
    a_mode_after: assert property (p_mode_after) else $error("Mode not applied after conversion"); // R20

    property p_result_bit;
        @(posedge CLOCK) disable iff (RST)
        rise && hw_shutdown_n_n_s && st_r.conv && st_r.k >= K_STROBE && st_r.k < K_LAST
        |=> DOUT == $past(dec_bit) && !STROBE_OUT;
    endproperty
    a_result_bit: assert property (p_result_bit) else $error("Decision not on output"); // R4
endmodule : sas_top

// [verification/sas_host_model.sv]
// Host serial controller model driving the converter link pins
`timescale 1ns/1ns
module sas_host_model (
    // Bench clock
    input wire logic clk,
    // Link outputs
    output logic sclk,
    output logic cs_n,
    output logic din,
    // Link inputs
    input wire logic dout,
    input wire logic dout_oe,
    input wire logic strobe,
    input wire logic strobe_oe
);
    // Floated pins read as the inverse of the last level, never a lucky match
    wire logic dout_pin = dout_oe ? dout : ~dout;
    wire logic strobe_pin = strobe_oe ? strobe : ~strobe;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din = 1'b0;
    end
    // ============================================================
    // Select and shift
    task automatic select(input logic lvl);
        @(posedge clk);
        cs_n <= lvl;
        repeat (8) @(posedge clk);
    endtask : select
    // Clock stands low outside frames; 8 system cycles a bit, far inside the hold limit
    task automatic shift(input int n, input logic [47:0] tx, output logic [47:0] rx, output logic [47:0] sb);
        rx = '0;
        sb = '0;
        @(posedge clk);
        for (int i = n - 1; i >= 0; i--) begin
            din <= tx[i];
            @(posedge clk);
            sclk <= 1'b1;
            repeat (4) @(posedge clk);
            sclk <= 1'b0;
            // Sample just before the next rise, after the output lag has settled
            repeat (3) @(posedge clk);
            rx[i] = dout_pin;
            sb[i] = strobe_pin;
        end
        din <= 1'b0;
        // One more edge lets a launch on the last fall show
        @(posedge clk);
    endtask : shift
endmodule : sas_host_model

// [verification/sas_top_tb_top.sv]
// Self-checking bench for the serial converter sequencer
`timescale 1ns/1ns
module sas_top_tb_top
    import sas_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic hw_shutdown_n_n = 1'b1;
    logic comp = 1'b1;
    logic [31:0] prdata;
    logic [1:0] pmode;
    logic [2:0] chan;
    logic pready, pslverr, sclk, cs_n, din, dout, dout_oe, strobe_out, strobe_out_oe, conv, hw_hw_shutdown_n, single;
    int err_total = 0;
    int compares = 0;
    int cycles = 0;
    always #50 clk = ~clk;
    sas_top i_sas_top (
        .CLOCK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .SCLK(sclk), .CS_N(cs_n),
        .DIN(din), .HW_SHUTDOWN_N(hw_shutdown_n_n), .DOUT(dout), .DOUT_OE(dout_oe), .STROBE_OUT(strobe_out), .STROBE_OUT_OE(strobe_out_oe),
        .COMP_DECISION(comp), .POWER_MODE(pmode), .CONV_ACTIVE(conv), .HW_SHUTDOWN(hw_hw_shutdown_n), .CHANNEL(chan),
        .SINGLE_ENDED(single)
    );
    sas_host_model i_sas_host_model (
        .clk(clk), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe), .strobe(strobe_out),
        .strobe_oe(strobe_out_oe)
    );
    // ============================================================
    // Checking and ending
    task automatic conclude();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude
    task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            err_total++;
            conclude();
        end
    end
    // ============================================================
    // Register bus
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One wait state: ready is seen at the second access-phase edge
        check("apb wait", n, 2);
    endtask : apb
    task automatic reg_rd(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] d;
        logic e;
        apb(1'b0, a, 32'h0000_0000, d, e);
        check("apb data", d, exp);
        check("apb error", e, exp_err);
    endtask : reg_rd
    task automatic reg_wr(input logic [11:0] a, input logic [31:0] wd);
        logic [31:0] d;
        logic e;
        apb(1'b1, a, wd, d, e);
        check("apb error", e, 1'b0);
    endtask : reg_wr
    // Control byte, strobe slot, twelve decisions, then zeros
    task automatic convert(input logic [7:0] cb, input logic [11:0] code);
        logic [47:0] rx, sb;
        i_sas_host_model.shift(24, {24'h0, cb, 16'h0}, rx, sb);
        check("strobe", sb, 48'h1 << 15);
        check("result bits", rx, 48'(code) << 3);
    endtask : convert
    // ============================================================
    // Main sequence
    initial begin
        logic [47:0] rx, sb;
        logic [7:0] cb;
        logic [1:0] pm;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (100) @(posedge clk);
        check("reset mode", pmode, PM_NORMAL);
        check("reset strobe", {strobe_out, conv}, 2'b00);
        reg_rd(OFS_STATUS, 32'h0000_0006, 1'b0);
        reg_rd(OFS_CTRL, 32'h0000_0000, 1'b0);
        reg_rd(OFS_TEST_CODE, 32'h0000_0000, 1'b0);
        reg_rd(12'h010, 32'h0000_0000, 1'b1);
        check("float", {dout_oe, strobe_out_oe}, 2'b00);
        i_sas_host_model.select(1'b0);
        check("drive", {dout_oe, strobe_out_oe, strobe_out}, 3'b110);
        i_sas_host_model.shift(16, 48'h0, rx, sb);
        check("idle out", rx, 48'h0);
        check("idle strobe", sb, 48'h0);
        check("no start", conv, 1'b0);
        convert(8'hFF, 12'hFFF);
        check("channel", {chan, single}, 4'hF);
        reg_wr(OFS_TEST_CODE, 32'h0000_0A5C);
        reg_wr(OFS_CTRL, 32'h0000_0001);
        reg_rd(OFS_TEST_CODE, 32'h0000_0A5C, 1'b0);
        for (int m = 3; m >= 0; m--) begin
            pm = 2'(m);
            cb = {2'b10, pm, pm[0], ~pm[0], pm};
            convert(cb, pm[0] ? 12'hA5C : 12'h25C);
            check("mode", pmode, pm);
            check("fields", {chan, single}, {1'b0, pm, ~pm[0]});
            reg_rd(OFS_STATUS, {16'h0, cb, 4'h0, 1'b0, pm, 1'b0}, 1'b0);
            reg_rd(OFS_RESULT, {20'h0, pm[0] ? 12'hA5C : 12'h25C}, 1'b0);
        end
        // Wake from deep sleep, then float the pins mid conversion
        i_sas_host_model.shift(8, 48'hBD, rx, sb);
        check("wake", {pmode, conv}, {PM_NORMAL, 1'b1});
        i_sas_host_model.select(1'b1);
        check("float busy", {dout_oe, strobe_out_oe, conv}, 3'b001);
        i_sas_host_model.select(1'b0);
        check("drive again", {dout_oe, strobe_out_oe, strobe_out}, 3'b110);
        i_sas_host_model.shift(16, 48'h0, rx, sb);
        check("soft mode", {pmode, conv}, {PM_QUICK_WAKE, 1'b0});
        i_sas_host_model.shift(40, {8'h00, 8'hBD, 8'h10, 8'h82, 16'h0000}, rx, sb);
        check("overlap strobe", sb, (48'h1 << 31) | (48'h1 << 15));
        check("overlap data", rx, (48'hA5C << 19) | (48'h25C << 3));
        check("overlap mode", pmode, PM_LOW_IDLE);
        i_sas_host_model.shift(12, 48'hFF0, rx, sb);
        hw_shutdown_n_n <= 1'b0;
        repeat (5) @(posedge clk);
        check("abort", {conv, hw_hw_shutdown_n}, 2'b01);
        hw_shutdown_n_n <= 1'b1;
        repeat (20) @(posedge clk);
        check("after shutdown", {pmode, hw_hw_shutdown_n}, {PM_NORMAL, 1'b0});
        i_sas_host_model.shift(8, 48'h0, rx, sb);
        convert(8'hFF, 12'hA5C);
        i_sas_host_model.select(1'b1);
        conclude();
    end
endmodule : sas_top_tb_top
